// file: hdl/disk_sector_sequencer.sv
/*
 Sequencer core: format, read, write, verify and search of disk sectors.
 Assumes a local processor on a strobed register port, an asynchronous
 read/reference clock pin, and a sector buffer on the byte port.
*/
// Chosen here: the address-and-strobe port and the placing of the registers.
// Function
// - Start 05 raises read gate, hunts mark
// - Command 08 reads, 09 writes data
// - Good ID continues; bad ID halts, bit4
// - Branch flag set when ready, read clears
// - Halt drops gates, keeps check register
// - Status bit 6 during data transfer
// - Command 14 ends after check bytes
// - Status bit 2 nonzero remainder
// - Format 10 waits index, gap, ID
// - Qualifier bit 5 fills 6C pattern
// - Start 15 waits index or sector mark
// - Command 11 writes data after ID
// - Command 15 writes zeros until mark
// - Check control 10 enables sector branching
// - Command 18 halts at next branch
// - Start 05 reads ID, sync A1
// - Hard-sector start 15 with a non-format command branches without gate
// - Verify bit checks, no transfer strobes
// - Search compares bytes, latches equal, low
// - Length bit 7 selects 128 or 256
// - Extend bit adds 256, clears on overflow
// - ID registers reloadable during transfer
// - Reciprocal shift exposes pattern bits 24-31
// - Hard format fills zeros to mark
`timescale 1ns/1ps
`default_nettype none
`include "disk_seq_consts.svh"
module disk_sector_sequencer
	import disk_seq_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic ref_clk,
	input wire logic index_pulse,
	input wire logic sector_mark,
	input wire logic [7:0] disk_in,
	input wire logic [7:0] buf_in,
	output logic [7:0] disk_out,
	output logic [7:0] buf_out,
	output logic read_gate,
	output logic write_gate,
	output logic byte_transfer_strobe
);
	byte_link_if link();
	seq_state_t state;
	logic [7:0] op_cmd, op_qual, ecc_ctl, search_en, data_len, gap_len;
	logic [7:0] id_cyl, id_head, id_sect, id_flag;
	logic [7:0] poly_lo, poly_hi;
	logic [7:0] status;
	logic [8:0] count;
	logic [2:0] idx_s, sm_s;
	logic idx_prev, sm_prev;
	logic writing, started_hard, ecc_ended, ecc_last;
	logic [7:0] cmp_pos;
	logic [7:0] ext_b;
	logic mark_ev, idx_ev, sm_ev;
	logic reg_wr_qual;
	function automatic logic is_fmt(input logic [7:0] c);
		is_fmt = (c == `CMD_FMT_GAP1) || (c == `CMD_FMT_DATA) || (c == `CMD_FMT_ID)
			|| (c == `CMD_FMT_TO_IDX) || (c == `CMD_FMT_ZERO);
	endfunction : is_fmt
	ref_clock_edges u_edges (.clock(clock), .nrst(nrst), .ref_clk(ref_clk), .link(link));
	check_register u_chk (
		.clock(clock),
		.nrst(nrst),
		.poly({poly_hi, 16'h0, poly_lo} ^ `POLY_FWD),
		.feedback_en(!ecc_ctl[`ECC_BIT_NOFB]),
		.sw_shift(wr && addr == `A_ECC_CTL && wdata[`ECC_BIT_SHIFT]),
		.sw_bit(wdata[`ECC_BIT_IN]),
		.sw_clear(wr && addr == `A_ECC_CTL && wdata[`ECC_BIT_CLR]),
		.link(link)
	);
	// Three-flop synchronisers for index and sector mark pins
	always_ff @(posedge clock) begin
		if (!nrst) begin
			idx_s <= 3'h0;
			sm_s <= 3'h0;
			idx_prev <= 1'b0;
			sm_prev <= 1'b0;
		end else begin
			idx_s <= {idx_s[1:0], index_pulse};
			sm_s <= {sm_s[1:0], sector_mark};
			if (idx_s[1] == idx_s[2]) idx_prev <= idx_s[2];
			if (sm_s[1] == sm_s[2]) sm_prev <= sm_s[2];
		end
	end
	assign idx_ev = (idx_s[1] == idx_s[2]) && idx_s[2] && !idx_prev;
	assign sm_ev = (sm_s[1] == sm_s[2]) && sm_s[2] && !sm_prev;
	assign mark_ev = idx_ev || (sm_ev && ecc_ctl == `SECT_BRANCH_EN);
	assign reg_wr_qual = wr && addr == `A_OPQUAL;
	// Plain register file; ID bytes may change mid-transfer
	always_ff @(posedge clock) begin
		if (!nrst) begin
			op_cmd <= 8'h00;
			ecc_ctl <= 8'h00;
			search_en <= 8'h00;
			data_len <= 8'h00;
			gap_len <= 8'h00;
			id_cyl <= 8'h00;
			id_head <= 8'h00;
			id_sect <= 8'h00;
			id_flag <= 8'h00;
			poly_lo <= 8'h00;
			poly_hi <= 8'h00;
		end else if (wr) begin
			if (addr == `A_OPCMD) op_cmd <= wdata;
			else if (addr == `A_ECC_CTL) ecc_ctl <= wdata;
			else if (addr == `A_SEARCH) search_en <= wdata;
			else if (addr == `A_DLEN) data_len <= wdata;
			else if (addr == `A_GAP) gap_len <= wdata;
			else if (addr == `A_CYL) id_cyl <= wdata;
			else if (addr == `A_HEAD) id_head <= wdata;
			else if (addr == `A_SECT) id_sect <= wdata;
			else if (addr == `A_FLAG) id_flag <= wdata;
			else if (addr == `A_POLY_LO) poly_lo <= wdata;
			else if (addr == `A_POLY_HI) poly_hi <= wdata;
		end
	end
	// Qualifier; extend bit self-clears on counter overflow
	always_ff @(posedge clock) begin
		if (!nrst) begin
			op_qual <= 8'h00;
		end else if (state == S_DATA && link.tick && count[7:0] == 8'hFF && op_qual[`Q_EXTEND]) begin
			op_qual <= reg_wr_qual ? (wdata & 8'h7F) : {1'b0, op_qual[6:0]};
		end else if (reg_wr_qual) begin
			op_qual <= wdata;
		end
	end
	// Sequencer
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state <= S_HALT;
			count <= 9'h0;
			writing <= 1'b0;
			started_hard <= 1'b0;
			ecc_ended <= 1'b0;
		end else if (state == S_HALT) begin
			if (wr && addr == `A_STATUS && wdata == `START_READ_ID) begin
				state <= S_SYNC;
				writing <= 1'b0;
				ecc_ended <= 1'b0;
			end else if (wr && addr == `A_STATUS && wdata == `START_WAIT) begin
				state <= S_WAIT_MARK;
				started_hard <= ecc_ctl == `SECT_BRANCH_EN;
				writing <= is_fmt(op_cmd);
				ecc_ended <= 1'b0;
			end
		end else if (state == S_BRANCH && op_cmd == `CMD_STOP_BR) begin
			state <= S_HALT;
		end else if (link.tick) begin
			case (state)
				S_WAIT_MARK: begin
					count <= 9'h0;
				end
				S_SYNC: begin
					if (disk_in == `SYNC_BYTE) begin
						state <= S_ID;
						count <= 9'h0;
					end
				end
				S_ID: begin
					count <= count + 9'h1;
					if (count == 9'd3 + 9'(`ID_CHECK_BYTES)) state <= S_ID_CHK;
				end
				S_ID_CHK: begin
					if (link.ecc[15:0] != 16'h0 || ext_b != id_sect) begin
						state <= S_HALT;
					end else begin
						state <= S_DATA;
						writing <= op_cmd == `CMD_WRITE;
						count <= {1'b0, ~data_len[`DLEN_BIT], 7'h0};
					end
				end
				S_GAP: begin
					count <= count + 9'h1;
					if (count[4:0] >= gap_len[4:0]) begin
						state <= S_WR_ID;
						count <= 9'h0;
					end
				end
				S_WR_ID: begin
					count <= count + 9'h1;
					if (count == 9'd5 + 9'(`ID_CHECK_BYTES)) state <= S_BRANCH;
				end
				S_DATA: begin
					count <= count + 9'h1;
					if (count[7:0] == 8'hFF && !op_qual[`Q_EXTEND]) begin
						state <= S_DATA_CHK;
						count <= 9'h0;
					end
				end
				S_DATA_CHK: begin
					count <= count + 9'h1;
					if (count == 9'(`DATA_CHECK_BYTES) - 9'h1) begin
						ecc_ended <= 1'b1;
						if (op_cmd == `CMD_END) state <= S_HALT;
						else if (op_cmd == `CMD_FMT_ZERO) state <= S_ZERO_FILL;
						else state <= S_BRANCH;
					end
				end
				S_BRANCH: begin
					if (op_cmd == `CMD_FMT_DATA) begin
						state <= S_DATA;
						count <= {1'b0, ~data_len[`DLEN_BIT], 7'h0};
					end else if (op_cmd == `CMD_FMT_ID || op_cmd == `CMD_FMT_GAP1) begin
						state <= S_GAP;
						count <= 9'h0;
					end else if (op_cmd == `CMD_READ || op_cmd == `CMD_WRITE) begin
						state <= S_SYNC;
						writing <= 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		if (nrst && state == S_WAIT_MARK && mark_ev) begin
			// Format start writes gap then ID; hard-sector read only branches
			state <= writing ? S_GAP : S_BRANCH;
		end else if (state == S_ZERO_FILL && mark_ev) begin
			state <= S_BRANCH;
		end
	end
	assign read_gate = (state == S_SYNC || state == S_ID || state == S_ID_CHK
		|| ((state == S_DATA || state == S_DATA_CHK) && !writing));
	assign write_gate = writing && (state == S_GAP || state == S_WR_ID || state == S_DATA
		|| state == S_DATA_CHK || state == S_ZERO_FILL || state == S_BRANCH);
	// Captured sector byte of the ID field for comparison
	always_ff @(posedge clock) begin
		if (!nrst) begin
			ext_b <= 8'h00;
		end else if (state == S_ID && link.tick && count == 9'd2) begin
			ext_b <= disk_in;
		end
	end
	assign link.ecc_clear = (state == S_HALT && wr && addr == `A_STATUS);
	assign link.ecc_feed = (state == S_ID || state == S_DATA || state == S_DATA_CHK);
	assign link.byte_val = writing ? disk_out : disk_in;
	// Outgoing byte to disk
	always_ff @(posedge clock) begin
		if (!nrst) begin
			disk_out <= 8'h00;
		end else if (state == S_ZERO_FILL || state == S_WAIT_MARK) begin
			disk_out <= `ZERO_BYTE;
		end else if (state == S_GAP) begin
			disk_out <= started_hard ? `ZERO_BYTE : `GAP_BYTE;
		end else if (state == S_DATA && is_fmt(op_cmd) && op_qual[`Q_FILL]) begin
			disk_out <= `FILL_BYTE;
		end else if (state == S_DATA) begin
			disk_out <= buf_in;
		end else if (state == S_DATA_CHK) begin
			// Top byte out; feeding it back shifts the register clean
			disk_out <= link.ecc[31:24];
		end else if (state == S_WR_ID) begin
			disk_out <= count[1:0] == 2'd0 ? id_cyl : count[1:0] == 2'd1 ? id_head
				: count[1:0] == 2'd2 ? id_sect : id_flag;
		end
	end
	// Byte moves to or from the buffer
	always_ff @(posedge clock) begin
		if (!nrst) begin
			buf_out <= 8'h00;
			byte_transfer_strobe <= 1'b0;
		end else begin
			byte_transfer_strobe <= state == S_DATA && link.tick && !op_qual[`Q_VERIFY]
				&& !(is_fmt(op_cmd) && op_qual[`Q_FILL]);
			if (state == S_DATA && link.tick && !writing) buf_out <= disk_in;
		end
	end
	// Status register
	always_ff @(posedge clock) begin
		if (!nrst) begin
			status <= 8'h10;
			cmp_pos <= 8'h00;
			ecc_last <= 1'b0;
		end else begin
			status[`ST_HALT] <= state == S_HALT;
			status[`ST_XFER] <= state == S_DATA;
			if (state == S_BRANCH || state == S_WAIT_MARK && mark_ev && !writing)
				status[`ST_BRANCH] <= 1'b1;
			else if (rd && addr == `A_STATUS)
				status[`ST_BRANCH] <= 1'b0;
			if (state == S_SYNC || state == S_WR_ID) status[`ST_AM] <= 1'b1;
			else if (state == S_DATA_CHK || state == S_HALT) status[`ST_AM] <= 1'b0;
			// Remainder judged a cycle late, once the last check byte is in
			ecc_last <= state == S_DATA_CHK && link.tick
				&& count == 9'(`DATA_CHECK_BYTES) - 9'h1 && !writing;
			if (ecc_last)
				status[`ST_ECC] <= next_nz(link.ecc);
			status[3] <= 1'b0;
			if (state == S_ID_CHK) begin
				status[`ST_EQ] <= 1'b1;
				status[`ST_LOW] <= 1'b0;
				cmp_pos <= 8'h00;
			end else if (state == S_DATA && link.tick && !writing && op_qual[`Q_SEARCH]
				&& search_en[`SRCH_BIT] && status[`ST_EQ]) begin
				status[`ST_EQ] <= buf_in == disk_in;
				status[`ST_LOW] <= buf_in < disk_in;
				cmp_pos <= cmp_pos + 8'h1;
			end
		end
	end
	function automatic logic next_nz(input logic [31:0] v);
		next_nz = v != 32'h0;
	endfunction : next_nz
	// Read port, data one cycle after strobe
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rdata <= 8'h00;
		end else if (rd) begin
			if (addr == `A_STATUS) rdata <= status;
			else if (addr == `A_ECC_LO) rdata <= link.ecc[7:0];
			else if (addr == `A_ECC_HI) rdata <= link.ecc[31:24];
			else if (addr == `A_OPQUAL) rdata <= op_qual;
			else if (addr == `A_CYL) rdata <= id_cyl;
			else if (addr == `A_HEAD) rdata <= id_head;
			else if (addr == `A_SECT) rdata <= id_sect;
			else if (addr == `A_FLAG) rdata <= id_flag;
			else rdata <= 8'h00;
		end else begin
			rdata <= 8'h00;
		end
	end
	chk_halt_gates: assert property (@(posedge clock) disable iff (!nrst)
		status[`ST_HALT] && $past(state == S_HALT) |-> !write_gate) else $error("gate in halt");
	chk_read_start: assert property (@(posedge clock) disable iff (!nrst)
		state == S_HALT && wr && addr == `A_STATUS && wdata == `START_READ_ID |=> read_gate)
		else $error("no read gate");
	chk_branch_clear: assert property (@(posedge clock) disable iff (!nrst)
		rd && addr == `A_STATUS && state != S_BRANCH && !(state == S_WAIT_MARK && mark_ev)
		|=> !status[`ST_BRANCH]) else $error("branch not cleared");
	chk_xfer_flag: assert property (@(posedge clock) disable iff (!nrst)
		state == S_DATA |=> status[`ST_XFER]) else $error("xfer flag");
	chk_verify_strobe: assert property (@(posedge clock) disable iff (!nrst)
		op_qual[`Q_VERIFY] && $past(op_qual[`Q_VERIFY]) |-> !byte_transfer_strobe)
		else $error("strobe in verify");
	chk_stop_branch: assert property (@(posedge clock) disable iff (!nrst)
		state == S_BRANCH && op_cmd == `CMD_STOP_BR |=> state == S_HALT ##1 status[`ST_HALT])
		else $error("no stop at branch");
	chk_fill_byte: assert property (@(posedge clock) disable iff (!nrst)
		state == S_DATA && is_fmt(op_cmd) && op_qual[`Q_FILL] && $stable(state)
		|=> disk_out == `FILL_BYTE) else $error("fill pattern");
	chk_zero_fill: assert property (@(posedge clock) disable iff (!nrst)
		state == S_ZERO_FILL && $past(state == S_ZERO_FILL) |-> disk_out == `ZERO_BYTE)
		else $error("zero fill");
	cov_read_data: cover property (@(posedge clock) state == S_ID_CHK ##1 state == S_DATA);
	cov_halt_bad_id: cover property (@(posedge clock) state == S_ID_CHK ##1 state == S_HALT);
	cov_format: cover property (@(posedge clock) state == S_GAP ##[1:300] state == S_WR_ID);
endmodule : disk_sector_sequencer
`default_nettype wire

// file: hdl/disk_seq_consts.svh
/*
 Register offsets, field positions, command codes and timing counts of the
 disk sector sequencer. Assumes inclusion by bare name from hdl/.
*/
`ifndef DISK_SEQ_CONSTS_SVH
`define DISK_SEQ_CONSTS_SVH
`define A_ECC_CTL 8'h71
`define A_ECC_LO 8'h72
`define A_ECC_HI 8'h73
`define A_POLY_LO 8'h74
`define A_POLY_HI 8'h77
`define A_OPCMD 8'h78
`define A_STATUS 8'h79
`define A_OPQUAL 8'h7A
`define A_SEARCH 8'hA4
`define A_DLEN 8'hC4
`define A_GAP 8'hD0
`define A_CYL 8'hE0
`define A_HEAD 8'hE1
`define A_SECT 8'hE2
`define A_FLAG 8'hE3
`define CMD_READ_ID 8'h05
`define CMD_READ 8'h08
`define CMD_WRITE 8'h09
`define CMD_FMT_GAP1 8'h10
`define CMD_FMT_DATA 8'h11
`define CMD_FMT_ID 8'h12
`define CMD_FMT_TO_IDX 8'h13
`define CMD_END 8'h14
`define CMD_FMT_ZERO 8'h15
`define CMD_STOP_BR 8'h18
`define START_READ_ID 8'h05
`define START_WAIT 8'h15
`define SECT_BRANCH_EN 8'h10
`define ST_EQ 0
`define ST_LOW 1
`define ST_ECC 2
`define ST_HALT 4
`define ST_BRANCH 5
`define ST_XFER 6
`define ST_AM 7
`define Q_SEARCH 4
`define Q_VERIFY 5
`define Q_FILL 5
`define Q_EXTEND 7
`define SRCH_BIT 2
`define DLEN_BIT 7
`define ECC_BIT_CLR 3
`define ECC_BIT_SHIFT 1
`define ECC_BIT_IN 0
`define ECC_BIT_NOFB 2
`define SYNC_BYTE 8'hA1
`define FILL_BYTE 8'h6C
`define GAP_BYTE 8'h4E
`define ZERO_BYTE 8'h00
`define ID_CHECK_BYTES 2
`define DATA_CHECK_BYTES 4
`define POLY_FWD 32'h0104C981
`endif

// file: hdl/disk_seq_pkg.sv
/*
 Types for the disk sector sequencer. No assumptions beyond SystemVerilog.
*/
package disk_seq_pkg;
	typedef enum logic [3:0] {
		S_HALT = 4'b0000,
		S_WAIT_MARK = 4'b0001,
		S_SYNC = 4'b0010,
		S_ID = 4'b0011,
		S_ID_CHK = 4'b0100,
		S_BRANCH = 4'b0101,
		S_DATA = 4'b0110,
		S_DATA_CHK = 4'b0111,
		S_GAP = 4'b1000,
		S_ZERO_FILL = 4'b1001,
		S_WR_ID = 4'b1010,
		S_WR_SYNC = 4'b1011
	} seq_state_t;
endpackage : disk_seq_pkg

// file: hdl/byte_link_if.sv
/*
 Byte link between sequencer and its byte-clock and check-register helpers.
 Assumes one clock domain on both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface byte_link_if;
	logic tick;
	logic [7:0] byte_val;
	logic ecc_clear;
	logic ecc_feed;
	logic [31:0] ecc;
	modport seq(input tick, input ecc, output byte_val, output ecc_clear, output ecc_feed);
	modport tim(output tick);
	modport chk(input tick, input byte_val, input ecc_clear, input ecc_feed, output ecc);
endinterface : byte_link_if
`default_nettype wire

// file: hdl/ref_clock_edges.sv
/*
 Finds rising edges of the read/reference clock. The pin is asynchronous
 and passes three flops; an edge counts when flops two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module ref_clock_edges (
	input wire logic clock,
	input wire logic nrst,
	input wire logic ref_clk,
	byte_link_if.tim link
);
	logic [2:0] sync;
	logic prev;
	logic [2:0] bitcnt;
	always_ff @(posedge clock) begin
		if (!nrst) begin
			sync <= 3'h0;
		end else begin
			sync <= {sync[1:0], ref_clk};
		end
	end
	// Stable level once the last two stages agree
	always_ff @(posedge clock) begin
		if (!nrst) begin
			prev <= 1'b0;
		end else if (sync[1] == sync[2]) begin
			prev <= sync[2];
		end
	end
	always_ff @(posedge clock) begin
		if (!nrst) begin
			bitcnt <= 3'h0;
		end else if (sync[1] == sync[2] && sync[2] && !prev) begin
			bitcnt <= bitcnt + 3'h1;
		end
	end
	// One byte time per eight bit cells
	assign link.tick = (sync[1] == sync[2]) && sync[2] && !prev && (bitcnt == 3'h7);
endmodule : ref_clock_edges
`default_nettype wire

// file: hdl/check_register.sv
/*
 32-bit check register. Feeds a byte per tick, or one bit per software
 shift. Assumes single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "disk_seq_consts.svh"
module check_register (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [31:0] poly,
	input wire logic feedback_en,
	input wire logic sw_shift,
	input wire logic sw_bit,
	input wire logic sw_clear,
	byte_link_if.chk link
);
	logic [31:0] next_ecc;
	logic [31:0] crc;
	function automatic logic [31:0] step(input logic [31:0] c, input logic b, input logic fb,
		input logic [31:0] p);
		logic top;
		top = (c[31] ^ b) & fb;
		step = {c[30:0], b & ~fb} ^ (top ? p : 32'h0);
	endfunction : step
	always_comb begin
		next_ecc = crc;
		if (link.tick && link.ecc_feed) begin
			for (int i = 7; i >= 0; i--) begin
				next_ecc = step(next_ecc, link.byte_val[i], 1'b1, poly);
			end
		end else if (sw_shift) begin
			next_ecc = step(crc, sw_bit, feedback_en, poly);
		end
	end
	// Halting leaves contents intact; only explicit clears reset it
	always_ff @(posedge clock) begin
		if (!nrst) begin
			crc <= 32'h0;
		end else if (link.ecc_clear || sw_clear) begin
			crc <= 32'h0;
		end else begin
			crc <= next_ecc;
		end
	end
	assign link.ecc = crc;
endmodule : check_register
`default_nettype wire

// file: bench/disk_channel_model.sv
/*
 Behavioural far side of the sequencer: read/reference clock, NRZ byte
 stream from the disk, capture of bytes written, and the sector buffer.
 Assumes the bench loads rd_q and reads wr_q and strobes hierarchically.
*/
`timescale 1ns/1ps
`default_nettype none
module disk_channel_model (
	input wire logic clock,
	input wire logic run,
	input wire logic read_gate,
	input wire logic write_gate,
	input wire logic [7:0] disk_out,
	input wire logic [7:0] buf_out,
	input wire logic byte_transfer_strobe,
	output logic ref_clk,
	output logic [7:0] disk_in,
	output logic [7:0] buf_in
);
	logic [7:0] rd_q[$];
	logic [7:0] wr_q[$];
	int edges;
	int strobes;
	initial begin
		ref_clk = 1'h0;
		disk_in = 8'h00;
		buf_in = 8'h00;
		edges = 0;
		strobes = 0;
		forever begin
			#62.5;
			// Clock stands still outside operations, always parked low
			if (run || ref_clk)
				ref_clk = ~ref_clk;
		end
	end
	// Bytes change mid-byte so the sequencer's byte tick sees them settled
	always @(posedge ref_clk) begin
		edges++;
		if (edges % 8 == 4) begin
			if (read_gate && rd_q.size() > 0)
				disk_in <= rd_q.pop_front();
			else
				disk_in <= ~disk_in;
			if (write_gate)
				wr_q.push_back(disk_out);
		end
	end
	// Sector buffer hands the next byte after each strobe
	always @(posedge clock) begin
		if (byte_transfer_strobe) begin
			strobes++;
			buf_in <= buf_in + 8'h01;
		end
	end
endmodule : disk_channel_model
`default_nettype wire

// file: bench/tb_top.sv
/*
 Self-checking bench of the disk sector sequencer: register tasks, a bad-ID
 read, a hard-sector wait, a soft format with fill pattern and a good read.
 Assumes the far side model in disk_channel_model.sv.
*/
`timescale 1ns/1ps
`default_nettype none
`include "disk_seq_consts.svh"
module tb_top;
	logic clock, nrst, wr, rd, ref_clk, index_pulse, sector_mark, run;
	logic read_gate, write_gate, byte_transfer_strobe;
	logic [7:0] addr, wdata, rdata, disk_in, buf_in, disk_out, buf_out, st;
	int err_count, num_checks, cycles, n, cnt, i, s0;
	disk_sector_sequencer u_disk_sector_sequencer (.clock, .nrst, .addr, .wdata, .wr, .rd,
		.rdata, .ref_clk, .index_pulse, .sector_mark, .disk_in, .buf_in, .disk_out, .buf_out,
		.read_gate, .write_gate, .byte_transfer_strobe);
	disk_channel_model u_disk_channel_model (.clock, .run, .read_gate, .write_gate, .disk_out,
		.buf_out, .byte_transfer_strobe, .ref_clk, .disk_in, .buf_in);
	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clock);
		wr <= 1'h0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'h1;
		@(posedge clock);
		rd <= 1'h0;
		#1 d = rdata;
	endtask : rd_reg
	// Polls one status bit, bounded by a number of reads
	task automatic wait_st(input int b, input logic v, input int lim);
		for (n = 0; n < lim; n++) begin
			rd_reg(`A_STATUS, st);
			if (st[b] === v)
				break;
		end
		chk({7'h00, st[b]}, {7'h00, v});
	endtask : wait_st
	task automatic pulse(input logic sect);
		@(posedge clock);
		if (sect)
			sector_mark <= 1'h1;
		else
			index_pulse <= 1'h1;
		repeat (8) @(posedge clock);
		sector_mark <= 1'h0;
		index_pulse <= 1'h0;
	endtask : pulse
	task print_verdict;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	// Whole run is about 62000 cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 90000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		nrst = 1'h0;
		{addr, wdata, wr, rd, index_pulse, sector_mark, run} = '0;
		{err_count, num_checks, cycles} = '0;
		repeat (5) @(posedge clock);
		nrst <= 1'h1;
		rd_reg(`A_STATUS, st);
		chk(st, 8'h10);
		chk({6'h00, read_gate, write_gate}, 8'h00);
		rd_reg(8'h00, st);
		chk(st, 8'h00);
		wr_reg(`A_CYL, 8'h2C);
		rd_reg(`A_CYL, st);
		chk(st, 8'h2C);
		// Soft read whose ID check bytes are wrong
		wr_reg(`A_ECC_CTL, 8'h00);
		wr_reg(`A_SECT, 8'h03);
		wr_reg(`A_DLEN, 8'h00);
		u_disk_channel_model.rd_q = '{8'h00, 8'h00, 8'h00, `SYNC_BYTE, 8'h2C, 8'h01, 8'h03,
			8'h00, 8'h5A, 8'hC3};
		run <= 1'h1;
		wr_reg(`A_OPCMD, `CMD_READ);
		wr_reg(`A_STATUS, `START_READ_ID);
		@(posedge clock);
		#1 chk({7'h00, read_gate}, 8'h01);
		wait_st(`ST_HALT, 1'h1, 3000);
		chk({6'h00, read_gate, write_gate}, 8'h00);
		chk(8'(u_disk_channel_model.strobes), 8'h00);
		run <= 1'h0;
		// Hard-sector wait for a sector mark, then stop at branch
		wr_reg(`A_ECC_CTL, `SECT_BRANCH_EN);
		wr_reg(`A_OPCMD, `CMD_READ_ID);
		wr_reg(`A_STATUS, `START_WAIT);
		run <= 1'h1;
		pulse(1'h1);
		wait_st(`ST_BRANCH, 1'h1, 300);
		chk({7'h00, read_gate}, 8'h00);
		wr_reg(`A_OPCMD, `CMD_STOP_BR);
		pulse(1'h1);
		wait_st(`ST_HALT, 1'h1, 1000);
		run <= 1'h0;
		// Soft format with fill pattern, 128-byte field
		wr_reg(`A_ECC_CTL, 8'h00);
		wr_reg(`A_GAP, 8'h02);
		wr_reg(`A_OPCMD, `CMD_FMT_GAP1);
		wr_reg(`A_OPQUAL, 8'h20);
		wr_reg(`A_STATUS, `START_WAIT);
		run <= 1'h1;
		pulse(1'h1);
		repeat (400) @(posedge clock);
		chk({7'h00, write_gate}, 8'h00);
		pulse(1'h0);
		wait_st(`ST_BRANCH, 1'h1, 2000);
		chk({7'h00, write_gate}, 8'h01);
		wr_reg(`A_STATUS, `START_READ_ID);
		@(posedge clock);
		#1 chk({7'h00, read_gate}, 8'h00);
		wr_reg(`A_OPCMD, `CMD_FMT_DATA);
		wait_st(`ST_XFER, 1'h1, 6000);
		s0 = u_disk_channel_model.strobes;
		wr_reg(`A_SECT, 8'h04);
		rd_reg(`A_SECT, st);
		chk(st, 8'h04);
		wr_reg(`A_OPCMD, `CMD_FMT_ZERO);
		wait_st(`ST_XFER, 1'h0, 16000);
		chk(8'(u_disk_channel_model.strobes - s0), 8'h00);
		repeat (2000) @(posedge clock);
		wr_reg(`A_OPCMD, `CMD_STOP_BR);
		pulse(1'h0);
		wait_st(`ST_HALT, 1'h1, 1000);
		chk({6'h00, read_gate, write_gate}, 8'h00);
		run <= 1'h0;
		n = u_disk_channel_model.wr_q.size();
		cnt = 0;
		for (i = 0; i < n; i++) begin
			if (u_disk_channel_model.wr_q[i] === `FILL_BYTE)
				cnt++;
		end
		chk({7'h00, cnt >= 128 && cnt < 136}, 8'h01);
		chk(u_disk_channel_model.wr_q[n - 1], `ZERO_BYTE);
		chk(u_disk_channel_model.wr_q[n - 5], `ZERO_BYTE);
		// Good read: zero ID, pad, 128 counting bytes, zero check bytes
		wr_reg(`A_OPQUAL, 8'h00);
		wr_reg(`A_SECT, 8'h00);
		u_disk_channel_model.rd_q = '{8'h00, 8'h00, `SYNC_BYTE};
		for (i = 0; i < 139; i++) begin
			u_disk_channel_model.rd_q.push_back((i >= 7 && i < 135) ? 8'(i - 7) : 8'h00);
		end
		s0 = u_disk_channel_model.strobes;
		run <= 1'h1;
		wr_reg(`A_OPCMD, `CMD_READ);
		wr_reg(`A_STATUS, `START_READ_ID);
		wait_st(`ST_XFER, 1'h1, 3000);
		wr_reg(`A_OPCMD, `CMD_END);
		wait_st(`ST_HALT, 1'h1, 16000);
		run <= 1'h0;
		chk(st, 8'h15);
		chk(8'(u_disk_channel_model.strobes - s0), 8'h80);
		chk(buf_out, 8'h7F);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
